// *** bench/msl_host_model.sv ***
// Purpose: Host controller driving the direct control pins.
// Assumes: Pins change just after a rising edge.
// Notes: Each level is held long enough to pass the input filter.
`timescale 1ns/1ps
module msl_host_model (
  // Clock and ready status.
  input  wire logic         sys_clk_i,
  input  wire logic         ready_i,
  // Control pins toward the driver.
  output msl_pkg::msl_ctl_t pin_o
);
  int fails = 0;

  // All pins start off.
  initial pin_o = '0;

  // Holds a new level for eight edges; the filter passes it on the fourth.
  task automatic set(input int k, input logic v);
    @(posedge sys_clk_i);
    pin_o[k] <= v;
    repeat (8) @(posedge sys_clk_i);
  endtask

  // Full on-off pulse; clear inputs act on its falling half.
  task automatic pulse(input int k);
    set(k, 1'b1);
    set(k, 1'b0);
  endtask

  task automatic cmd(input int k);
    int n;
    n = 0;
    while (ready_i !== 1'b1 && n < 200) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n == 200) fails++;
    pulse(k);
  endtask
endmodule

// *** bench/msl_io_status_properties.sv ***
// Purpose: Port-level properties of the motor I/O status block.
// Assumes: The overspeed threshold keeps its reset value.
// Notes: Bound into every msl_io_status instance below.
`timescale 1ns/1ps
module msl_io_status_properties #(
  parameter int MS_CYCLES = 50000
) (
  // Clock, reset and bus.
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  input  wire logic         avs_read_i,
  input  wire logic         avs_write_i,
  input  wire logic         avs_waitrequest_o,
  // Inputs.
  input  msl_pkg::msl_ctl_t  pin_i,
  input  msl_pkg::msl_core_t core_i,
  input  wire logic [12:0]  speed_i,
  // Outputs.
  input  wire logic         alarm_out_o,
  input  wire logic         warning_out_o,
  input  wire logic         home_o,
  input  wire logic         motion_o,
  input  wire logic         current_on_o,
  input  wire logic         brake_release_o,
  input  wire logic         stop_req_o,
  input  wire logic         preset_load_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // A bus request gets exactly one cycle of answer.
  sequence req_rise_s; $rose(avs_read_i || avs_write_i); endsequence
  sequence one_wait_s; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  bus_wait_a: assert property (req_rise_s |=> one_wait_s) else $error("Bus answer not one cycle.");
  alarm_drive_a: assert property (!alarm_out_o [*3] |-> !current_on_o && stop_req_o)
    else $error("Alarm left drive on.");
  motion_follow_a: assert property (motion_o == $past(core_i.running))
    else $error("Motion output wrong.");
  preset_pulse_a: assert property (preset_load_o |=> !preset_load_o) else $error("Load pulse long.");
  preset_block_a: assert property ((core_i.running || !alarm_out_o) [*3] |=> !preset_load_o)
    else $error("Preset taken while blocked.");
  cut_drive_a: assert property (pin_i.cut [*8] |-> !current_on_o && brake_release_o)
    else $error("Cut input ignored.");
  warn_speed_a: assert property (warning_out_o == ($past(speed_i) > 13'h1194))
    else $error("Warning output wrong.");
  home_idle_a: assert property (home_o |-> !$past(core_i.running))
    else $error("Home output while moving.");
endmodule

bind msl_io_status msl_io_status_properties #(.MS_CYCLES(MS_CYCLES)) u_props (.sys_clk_i, .resetn_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .pin_i, .core_i, .speed_i, .alarm_out_o, .warning_out_o,
  .home_o, .motion_o, .current_on_o, .brake_release_o, .stop_req_o, .preset_load_o);

// *** bench/msl_io_status_test.sv ***
// Purpose: Self-checking bench for the motor I/O status block.
// Assumes: Short millisecond so that timed alarms fit the run.
// Notes: Random values come from a fixed seed.
`timescale 1ns/1ps
`include "msl_params.svh"
module msl_io_status_test;
  localparam int MS = 5;
  localparam logic [5:0] OFS [8] = '{`MSL_CTRL_OFS, `MSL_PRESET_OFS, `MSL_OVLD_OFS, `MSL_DEVON_OFS,
    `MSL_DEVOFF_OFS, `MSL_COMM_OFS, `MSL_OVSPD_OFS, 6'h3c};
  localparam logic [31:0] RST [8] = '{32'h0, 32'h0, 32'h32, 32'h12c, 32'h2710, 32'h0, 32'h1194, 32'h0};
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  msl_pkg::msl_ctl_t pin_i;
  msl_pkg::msl_core_t core_i = 6'h01;
  logic [23:0] cmd_pos_i = 24'h0, preset_pos_o, last_pos, v;
  logic [14:0] deviation_i = 15'h0;
  logic [12:0] speed_i = 13'h0;
  logic overload_i = 1'b0, abs_err_i = 1'b0, fatal_i = 1'b0, origin_set_i = 1'b0;
  logic comm_frame_i = 1'b0, pos_start_i = 1'b0;
  logic [1:0] seen;
  logic avs_waitrequest_o, alarm_out_o, warning_out_o, ready_o, home_o, motion_o, alarm_led_o;
  logic current_on_o, brake_release_o, stop_req_o, tool_allow_o, preset_load_o;
  int n_errors = 0, total_checks = 0, n_load = 0, seed = 7, i;

  msl_io_status #(.MS_CYCLES(MS)) DUT (.sys_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .pin_i, .core_i, .cmd_pos_i, .deviation_i,
    .speed_i, .overload_i, .abs_err_i, .fatal_i, .comm_frame_i, .pos_start_i, .origin_set_i,
    .alarm_out_o, .warning_out_o, .ready_o, .home_o, .motion_o, .alarm_led_o, .current_on_o,
    .brake_release_o, .stop_req_o, .tool_allow_o, .preset_load_o, .preset_pos_o);
  msl_host_model host (.sys_clk_i, .ready_i(ready_o), .pin_o(pin_i));

  // Free-running 50 MHz clock.
  always #10 sys_clk_i = ~sys_clk_i;

  // Counts load pulses and keeps the value that came with the last one.
  always @(posedge sys_clk_i) if (preset_load_o === 1'b1) begin
    n_load <= n_load + 1;
    last_pos <= preset_pos_o;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test(input bit timed_out);
    n_errors += host.fails + timed_out;
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Bus cycle held until waitrequest is seen low; an idle edge follows.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n == 20) stop_test(1'b1);
    else @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e); bus(1'b0, a, 32'h0); chk(q, e); endtask
  task automatic cyc(input int n); repeat (n) @(posedge sys_clk_i); endtask

  // Main sequence; the fatal alarm comes just before the reset since only reset clears it.
  initial begin
    cyc(20);
    resetn_i <= 1'b1;
    cyc(10);
    for (i = 0; i < 8; i++) rd(OFS[i], RST[i]);
    chk({alarm_out_o, current_on_o, tool_allow_o, ready_o}, 32'hf);
    for (i = 0; i < 3; i++) begin
      v = (i == 0) ? 24'h800000 : (i == 1) ? 24'h7fffff : 24'($random(seed));
      wr(`MSL_PRESET_OFS, {8'h00, v});
      host.cmd(1);
      chk(n_load, i + 1);
      chk(last_pos, v);
    end
    wr(`MSL_NETIN_OFS, 32'h2);
    wr(`MSL_NETIN_OFS, 32'h0);
    chk(n_load, 4);
    core_i.running <= 1'b1;
    host.pulse(1);
    chk({n_load[3:0], motion_o}, 32'h9);
    core_i.running <= 1'b0;
    deviation_i <= 15'h012c;
    cyc(6);
    chk(alarm_out_o, 32'h1);
    deviation_i <= 15'h012d + 15'($random(seed) & 255);
    cyc(6);
    chk({alarm_out_o, current_on_o, stop_req_o, ready_o}, 32'h2);
    rd(`MSL_NETOUT_OFS, 32'h9);
    rd(`MSL_ALMC_OFS, 32'h2);
    deviation_i <= 15'h0;
    host.set(2, 1'b1);
    chk(alarm_out_o, 32'h0);
    host.set(2, 1'b0);
    chk(alarm_out_o, 32'h1);
    abs_err_i <= 1'b1;
    deviation_i <= 15'h7fff;
    cyc(1);
    abs_err_i <= 1'b0;
    cyc(6);
    rd(`MSL_ALMC_OFS, 32'h12);
    host.pulse(3);
    rd(`MSL_ALMC_OFS, 32'h2);
    deviation_i <= 15'h0;
    host.pulse(2);
    rd(`MSL_ALMC_OFS, 32'h0);
    comm_frame_i <= 1'b1;
    wr(`MSL_COMM_OFS, 32'h2);
    cyc(4);
    rd(`MSL_ALMC_OFS, 32'h0);
    comm_frame_i <= 1'b0;
    cyc(12);
    rd(`MSL_ALMC_OFS, 32'h8);
    wr(`MSL_COMM_OFS, 32'h0);
    host.pulse(2);
    rd(`MSL_ALMC_OFS, 32'h0);
    wr(`MSL_OVLD_OFS, 32'h2);
    overload_i <= 1'b1;
    cyc(450);
    chk(alarm_out_o, 32'h1);
    cyc(600);
    chk(alarm_out_o, 32'h0);
    overload_i <= 1'b0;
    host.pulse(2);
    host.set(0, 1'b1);
    chk({current_on_o, brake_release_o, ready_o}, 32'h2);
    host.set(0, 1'b0);
    chk({alarm_out_o, ready_o}, 32'h3);
    for (i = 0; i < 6; i++) begin
      core_i <= 6'h01 ^ 6'(1 << i);
      cyc(2);
      chk(ready_o, 32'h0);
    end
    core_i <= 6'h01;
    cyc(2);
    chk(ready_o, 32'h1);
    for (i = 0; i < 6; i++) begin
      speed_i <= (i == 0) ? 13'h1194 : (i == 1) ? 13'h1195 : 13'($random(seed));
      cyc(2);
      chk(warning_out_o, speed_i > 13'h1194);
    end
    speed_i <= 13'h0;
    wr(`MSL_CTRL_OFS, 32'h4);
    cyc(1);
    chk(tool_allow_o, 32'h0);
    host.set(4, 1'b1);
    chk(tool_allow_o, 32'h1);
    wr(`MSL_CTRL_OFS, 32'hc);
    cyc(2);
    chk(tool_allow_o, 32'h0);
    wr(`MSL_NETIN_OFS, 32'h10);
    cyc(2);
    chk(tool_allow_o, 32'h1);
    wr(`MSL_CTRL_OFS, 32'h0);
    origin_set_i <= 1'b1;
    cyc(1);
    origin_set_i <= 1'b0;
    cyc(3);
    chk(home_o, 32'h1);
    cmd_pos_i <= 24'h5;
    cyc(3);
    chk(home_o, 32'h0);
    wr(`MSL_CTRL_OFS, 32'h1);
    cyc(2);
    chk(home_o, 32'h1);
    core_i.running <= 1'b1;
    cyc(3);
    chk({home_o, motion_o}, 32'h1);
    core_i.running <= 1'b0;
    fatal_i <= 1'b1;
    cyc(1);
    fatal_i <= 1'b0;
    cyc(4);
    host.pulse(2);
    chk(alarm_out_o, 32'h0);
    seen = 2'b00;
    repeat (1300) begin
      @(posedge sys_clk_i);
      seen = seen | {alarm_led_o, ~alarm_led_o};
    end
    chk(seen, 32'h3);
    resetn_i <= 1'b0;
    cmd_pos_i <= 24'h0;
    cyc(3);
    resetn_i <= 1'b1;
    cyc(2);
    chk({alarm_out_o, alarm_led_o, home_o}, 32'h4);
    wr(`MSL_CTRL_OFS, 32'h2);
    pos_start_i <= 1'b1;
    cyc(1);
    pos_start_i <= 1'b0;
    cyc(2);
    rd(`MSL_ALMC_OFS, 32'h4);
    stop_test(1'b0);
  end
endmodule

// *** src/msl_io_status.sv ***
// Purpose: Control input handling, alarm, warning, ready and home outputs.
// Assumes: Core status is on sys_clk_i; direct pins are asynchronous.
// Notes: Registers sit behind an Avalon-MM slave with waitrequest.
`timescale 1ns/1ps
`include "msl_params.svh"

module msl_io_status #(
  parameter int MS_CYCLES = `MSL_MS_NS / `MSL_CLK_NS
) (
  // Clock and reset.
  input  wire logic               sys_clk_i,
  input  wire logic               resetn_i,
  // Avalon-MM slave.
  input  wire logic [5:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // Direct control pins.
  input  msl_pkg::msl_ctl_t       pin_i,
  // Motion core status.
  input  msl_pkg::msl_core_t      core_i,
  input  wire logic [23:0]        cmd_pos_i,
  input  wire logic [14:0]        deviation_i,
  input  wire logic [12:0]        speed_i,
  input  wire logic               overload_i,
  input  wire logic               abs_err_i,
  input  wire logic               fatal_i,
  input  wire logic               comm_frame_i,
  input  wire logic               pos_start_i,
  input  wire logic               origin_set_i,
  // Direct outputs.
  output logic                    alarm_out_o,
  output logic                    warning_out_o,
  output logic                    ready_o,
  output logic                    home_o,
  output logic                    motion_o,
  // Drive and panel control.
  output logic                    alarm_led_o,
  output logic                    current_on_o,
  output logic                    brake_release_o,
  output logic                    stop_req_o,
  output logic                    tool_allow_o,
  output logic                    preset_load_o,
  output logic [23:0]             preset_pos_o
);

  // Software registers.
  logic [5:0]         ctrl_reg;
  logic [23:0]        preset_reg;
  logic [8:0]         ovld_reg;
  logic [14:0]        devon_reg;
  logic [14:0]        devoff_reg;
  logic [13:0]        comm_reg;
  logic [12:0]        ovspd_reg;
  msl_pkg::msl_ctl_t  net_reg;

  // Bus handshake.
  logic               wait_reg;
  logic [31:0]        rdata_reg;

  // Input synchroniser stages.
  logic [5:0]         s1_reg;
  logic [5:0]         s2_reg;
  logic [5:0]         s3_reg;
  logic [5:0]         pin_q_reg;
  logic [5:0]         pin_v;

  // Edge history and state.
  msl_pkg::msl_ctl_t  eff;
  msl_pkg::msl_ctl_t  prev_reg;
  msl_pkg::msl_alm_t  alm_reg;
  logic [5:0]         alm_next;
  logic [5:0]         raise;
  logic [5:0]         clr;
  logic               origin_reg;
  logic               home_done_reg;
  logic               warn_reg;

  // Time bases and counters.
  logic [15:0]        ms_cnt_reg;
  logic [6:0]         tenth_cnt_reg;
  logic [7:0]         blink_cnt_reg;
  logic               blink_reg;
  logic [8:0]         ovl_cnt_reg;
  logic [13:0]        comm_cnt_reg;

  // Bus decode.
  wire req      = avs_read_i | avs_write_i;
  wire wr_take  = avs_write_i & ~wait_reg;
  wire wr_ctrl  = wr_take & (avs_address_i == `MSL_CTRL_OFS);
  wire wr_pre   = wr_take & (avs_address_i == `MSL_PRESET_OFS);
  wire wr_ovld  = wr_take & (avs_address_i == `MSL_OVLD_OFS);
  wire wr_devon = wr_take & (avs_address_i == `MSL_DEVON_OFS);
  wire wr_devof = wr_take & (avs_address_i == `MSL_DEVOFF_OFS);
  wire wr_comm  = wr_take & (avs_address_i == `MSL_COMM_OFS);
  wire wr_ovspd = wr_take & (avs_address_i == `MSL_OVSPD_OFS);
  wire wr_net   = wr_take & (avs_address_i == `MSL_NETIN_OFS);

  // Time base ticks.
  wire ms_tick    = (ms_cnt_reg == 16'(MS_CYCLES - 1));
  wire tenth_tick = ms_tick & (tenth_cnt_reg == 7'(`MSL_TENTH_MS - 1));
  wire blink_tick = ms_tick & (blink_cnt_reg == 8'(`MSL_BLINK_MS - 1));

  // Effective inputs from direct and network sources.
  // unlock assignment merge
  wire udir = ctrl_reg[`MSL_CTRL_UDIR];
  wire unet = ctrl_reg[`MSL_CTRL_UNET];
  wire edir = ctrl_reg[`MSL_CTRL_EDIR];
  wire enet = ctrl_reg[`MSL_CTRL_ENET];
  assign pin_v = pin_i;
  assign eff.unlock = (~udir | pin_q_reg[4]) & (~unet | net_reg.unlock);
  assign eff.excite = (~edir | pin_q_reg[5]) & (~enet | net_reg.excite);
  assign eff.cut    = pin_q_reg[0] | net_reg.cut;
  assign eff.preset = pin_q_reg[1] | net_reg.preset;
  assign eff.aclr   = pin_q_reg[2] | net_reg.aclr;
  assign eff.pclr   = pin_q_reg[3] | net_reg.pclr;

  // Edge detection on the merged inputs.
  // preset rising edge
  wire preset_rise = eff.preset & ~prev_reg.preset;
  wire aclr_fall   = ~eff.aclr & prev_reg.aclr;
  wire pclr_fall   = ~eff.pclr & prev_reg.pclr;
  wire alarm_any   = |alm_reg;
  wire preset_ok   = preset_rise & ~alarm_any & ~core_i.running;

  // Alarm sources.
  // overload time threshold
  assign raise[0] = (ovl_cnt_reg >= ovld_reg);
  assign raise[1] = current_on_o ? (deviation_i > devon_reg)
                                 : (deviation_i > devoff_reg);
  assign raise[2] = ctrl_reg[`MSL_CTRL_HINC] & pos_start_i & ~origin_reg;
  assign raise[3] = (comm_reg != 14'h0000) & (comm_cnt_reg >= comm_reg);
  assign raise[4] = abs_err_i;
  assign raise[5] = fatal_i;

  // Clears; the absolute and fatal alarms resist the alarm clear.
  // non-resettable alarm mask
  assign clr[3:0] = {4{aclr_fall}};
  assign clr[4]   = pclr_fall;
  assign clr[5]   = 1'b0;
  // A cause still present sets again, so set wins over clear.
  assign alm_next = (alm_reg & ~clr) | raise;
  wire alarm_nx   = |alm_next;

  // Output terms.
  // current cut effect
  wire cur_next   = eff.excite & ~eff.cut & ~alarm_nx;
  wire brake_next = eff.cut | cur_next;
  wire ready_next = core_i.power_ok & ~core_i.start_any & ~eff.cut
                  & eff.excite & ~core_i.stop & ~alarm_nx
                  & ~core_i.running & ~core_i.tool_busy
                  & ~core_i.serial_busy;
  wire home_pos   = origin_reg & (cmd_pos_i == 24'h000000)
                  & ~core_i.running;
  // homing complete select
  // The running term drops the output on the first moving cycle, not one late.
  wire home_next  = ctrl_reg[`MSL_CTRL_HMODE] ? (home_done_reg & ~core_i.running) : home_pos;

  // Register read mux; unmapped offsets read as zero.
  // network outputs active high
  wire [31:0] stat_w = {23'h000000, cur_next, eff.excite, eff.unlock,
                        origin_reg, motion_o, home_o, ready_o,
                        warn_reg, alarm_any};
  wire [31:0] nout_w = {27'h0000000, motion_o, home_o, ready_o,
                        warn_reg, alarm_any};
  wire [31:0] rd_mux =
    (avs_address_i == `MSL_CTRL_OFS)   ? {26'h0000000, ctrl_reg} :
    (avs_address_i == `MSL_PRESET_OFS) ? {8'h00, preset_reg} :
    (avs_address_i == `MSL_OVLD_OFS)   ? {23'h000000, ovld_reg} :
    (avs_address_i == `MSL_DEVON_OFS)  ? {17'h00000, devon_reg} :
    (avs_address_i == `MSL_DEVOFF_OFS) ? {17'h00000, devoff_reg} :
    (avs_address_i == `MSL_COMM_OFS)   ? {18'h00000, comm_reg} :
    (avs_address_i == `MSL_OVSPD_OFS)  ? {19'h00000, ovspd_reg} :
    (avs_address_i == `MSL_NETIN_OFS)  ? {26'h0000000, net_reg} :
    (avs_address_i == `MSL_STAT_OFS)   ? stat_w :
    (avs_address_i == `MSL_ALMC_OFS)   ? {26'h0000000, alm_reg} :
    (avs_address_i == `MSL_NETOUT_OFS) ? nout_w : 32'h00000000;

  // Bus handshake: one wait cycle, then answer for exactly one cycle.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg  <= ~(req & wait_reg);
      rdata_reg <= rd_mux;
    end
  end

  // Configuration registers, written on the accepting edge only.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg   <= `MSL_CTRL_RST;
      preset_reg <= `MSL_PRESET_RST;
      ovld_reg   <= `MSL_OVLD_RST;
      devon_reg  <= `MSL_DEVON_RST;
      devoff_reg <= `MSL_DEVOFF_RST;
      comm_reg   <= `MSL_COMM_RST;
      ovspd_reg  <= `MSL_OVSPD_RST;
    end else begin
      if (wr_ctrl)  ctrl_reg   <= avs_writedata_i[5:0];
      if (wr_pre)   preset_reg <= avs_writedata_i[23:0];
      if (wr_ovld)  ovld_reg   <= avs_writedata_i[8:0];
      if (wr_devon) devon_reg  <= avs_writedata_i[14:0];
      if (wr_devof) devoff_reg <= avs_writedata_i[14:0];
      if (wr_comm)  comm_reg   <= avs_writedata_i[13:0];
      if (wr_ovspd) ovspd_reg  <= avs_writedata_i[12:0];
    end
  end

  // Network input bits, same clock, so no synchroniser needed.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      net_reg <= 6'h00;
    end else if (wr_net) begin
      net_reg <= avs_writedata_i[5:0];
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree,
  // which also rejects a single-cycle glitch.
  // three stage sync
  generate
    for (genvar i = 0; i < 6; i++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          s1_reg[i]    <= 1'b0;
          s2_reg[i]    <= 1'b0;
          s3_reg[i]    <= 1'b0;
          pin_q_reg[i] <= 1'b0;
        end else begin
          s1_reg[i] <= pin_v[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) pin_q_reg[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

  // Millisecond, tenth-second and blink time bases.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_cnt_reg    <= 16'h0000;
      tenth_cnt_reg <= 7'h00;
      blink_cnt_reg <= 8'h00;
      blink_reg     <= 1'b0;
    end else begin
      ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
      if (tenth_tick) tenth_cnt_reg <= 7'h00;
      else if (ms_tick) tenth_cnt_reg <= tenth_cnt_reg + 7'h01;
      if (blink_tick) blink_cnt_reg <= 8'h00;
      else if (ms_tick) blink_cnt_reg <= blink_cnt_reg + 8'h01;
      if (blink_tick) blink_reg <= ~blink_reg;
    end
  end

  // Overload time and serial silence counters, both saturating.
  // overload duration count
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovl_cnt_reg  <= 9'h000;
      comm_cnt_reg <= 14'h0000;
    end else begin
      if (!overload_i) ovl_cnt_reg <= 9'h000;
      else if (tenth_tick && ovl_cnt_reg != 9'h1ff)
        ovl_cnt_reg <= ovl_cnt_reg + 9'h001;
      if (comm_frame_i) comm_cnt_reg <= 14'h0000;
      else if (ms_tick && comm_cnt_reg != 14'h3fff)
        comm_cnt_reg <= comm_cnt_reg + 14'h0001;
    end
  end

  // Alarm latch, edge history and warning.
  // warning from overspeed
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alm_reg  <= 6'h00;
      prev_reg <= 6'h00;
      warn_reg <= 1'b0;
    end else begin
      alm_reg  <= alm_next;
      prev_reg <= eff;
      warn_reg <= (speed_i > ovspd_reg);
    end
  end

  // Origin and homing-complete state; a new origin beats a move.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      origin_reg    <= 1'b0;
      home_done_reg <= 1'b0;
    end else begin
      if (origin_set_i || preset_ok) origin_reg <= 1'b1;
      if (origin_set_i || preset_ok) home_done_reg <= 1'b1;
      else if (core_i.running) home_done_reg <= 1'b0;
    end
  end

  // Preset request toward the motion core.
  // load preset value
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      preset_load_o <= 1'b0;
      preset_pos_o  <= 24'h000000;
    end else begin
      preset_load_o <= preset_ok;
      if (preset_ok) preset_pos_o <= preset_reg;
    end
  end

  // Direct outputs; the alarm output is normally closed, so it is
  // high while healthy and drops on any alarm.
  // direct alarm off
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_out_o   <= 1'b1;
      warning_out_o <= 1'b0;
      ready_o       <= 1'b0;
      home_o        <= 1'b0;
      motion_o      <= 1'b0;
    end else begin
      alarm_out_o   <= ~alarm_nx;
      warning_out_o <= (speed_i > ovspd_reg);
      ready_o       <= ready_next;
      home_o        <= home_next;
      motion_o      <= core_i.running;
    end
  end

  // Drive side: current, brake, stop, LED and tool permission.
  // alarm stop actions
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      current_on_o    <= 1'b0;
      brake_release_o <= 1'b0;
      stop_req_o      <= 1'b0;
      alarm_led_o     <= 1'b0;
      tool_allow_o    <= 1'b0;
    end else begin
      current_on_o    <= cur_next;
      brake_release_o <= brake_next;
      stop_req_o      <= alarm_nx;
      alarm_led_o     <= alarm_nx & blink_reg;
      tool_allow_o    <= eff.unlock;
    end
  end

  // Bus outputs come straight from their flops.
  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o    = rdata_reg;

endmodule

// *** src/msl_params.svh ***
// Purpose: Constants for the motor I/O status block.
// Assumes: 50 MHz system clock, byte addressed registers.
// Notes: Included by the package user files by bare name.
`ifndef MSL_PARAMS_SVH
`define MSL_PARAMS_SVH

// Timing, each time in its own unit.
`define MSL_CLK_NS     20
`define MSL_MS_NS      1000000
`define MSL_BLINK_MS   250
`define MSL_TENTH_MS   100

// Register byte offsets.
`define MSL_CTRL_OFS   6'h00
`define MSL_PRESET_OFS 6'h04
`define MSL_OVLD_OFS   6'h08
`define MSL_DEVON_OFS  6'h0c
`define MSL_DEVOFF_OFS 6'h10
`define MSL_COMM_OFS   6'h14
`define MSL_OVSPD_OFS  6'h18
`define MSL_NETIN_OFS  6'h1c
`define MSL_STAT_OFS   6'h20
`define MSL_ALMC_OFS   6'h24
`define MSL_NETOUT_OFS 6'h28

// Control register field positions.
`define MSL_CTRL_HMODE 0
`define MSL_CTRL_HINC  1
`define MSL_CTRL_UDIR  2
`define MSL_CTRL_UNET  3
`define MSL_CTRL_EDIR  4
`define MSL_CTRL_ENET  5

// Reset values.
`define MSL_CTRL_RST   6'h00
`define MSL_PRESET_RST 24'h000000
`define MSL_OVLD_RST   9'h032
`define MSL_DEVON_RST  15'h012c
`define MSL_DEVOFF_RST 15'h2710
`define MSL_COMM_RST   14'h0000
`define MSL_OVSPD_RST  13'h1194

`endif

// *** src/msl_pkg.sv ***
// Purpose: Types shared by the motor I/O status block.
// Assumes: Nothing beyond the parameter header.
// Notes: Lowest declared field sits in bit 0.
package msl_pkg;

  // Control inputs, direct pins and network bits alike.
  typedef struct packed {
    logic excite;
    logic unlock;
    logic pclr;
    logic aclr;
    logic preset;
    logic cut;
  } msl_ctl_t;

  // Alarm causes; resettable ones sit low.
  typedef struct packed {
    logic fatal;
    logic abs;
    logic comm;
    logic hinc;
    logic dev;
    logic ovl;
  } msl_alm_t;

  // State reported by the motion core.
  typedef struct packed {
    logic serial_busy;
    logic tool_busy;
    logic running;
    logic stop;
    logic start_any;
    logic power_ok;
  } msl_core_t;

endpackage
